// ===== serial_ctrl.sv
// register, transmit and flag logic of the asynchronous serial transceiver
`timescale 1ns/1ns
module serial_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_in,
  output logic serial_out,
  output logic irq_tx,
  output logic irq_rx,
  output logic irq_err
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic a_valid;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic module_on, nine_bit, wake_sel, par_en, par_odd;
    logic tx_on, rx_on, standby, break_send;
    logic txempty_en, txdone_en, rxfull_en, quiet_en;
    logic tx_ninth, or_en, nf_en, fe_en, pe_en;
    logic [15:0] baud;
    logic tbe, tc, rbf, quiet, ovr, noise, fe, pe;
    logic [7:0] seen;
    logic quiet_armed;
    logic [15:0] baud_cnt;
    logic [3:0] tx_bits;
    logic [10:0] tx_shift;
    logic [7:0] tx_hold;
    logic pre_pend;
    logic brk_tail;
    logic serial_out;
    logic irq_tx, irq_rx, irq_err;
  } st_t;
  st_t q;
  st_t n;
  serial_ctrl_pkg::rx_event_t rx_ev;
  logic [7:0] data_buffer;
  logic rx_ninth;
  logic a_go, rd_stat, rd_data, wr_go, tick, wake, accept, perr;
  logic [3:0] len;
  logic [7:0] stat;

  serial_rx rx (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .enable(q.module_on & q.rx_on),
    .line(q.sync2),
    .nine_bit(q.nine_bit),
    .bit_cycles(q.baud),
    .rx_ev(rx_ev)
  );

  // ----------------------------------------------------------------
  // bus decode and receive qualifiers
  // ----------------------------------------------------------------
  assign a_go = hsel & hready & htrans[1];
  assign rd_stat = a_go & !hwrite & (haddr[7:0] == serial_ctrl_pkg::OFS_STATUS);
  assign rd_data = a_go & !hwrite & (haddr[7:0] == serial_ctrl_pkg::OFS_DATA);
  assign wr_go = q.a_valid;
  assign tick = q.module_on & (q.baud_cnt == 16'h0000);
  assign len = q.nine_bit ? serial_ctrl_pkg::CHAR_LEN_9 : serial_ctrl_pkg::CHAR_LEN_8;
  assign wake = rx_ev.done & q.standby & q.wake_sel
    & (q.nine_bit ? rx_ev.data[8] : rx_ev.data[7]);
  // in standby only a waking character is taken in
  assign accept = rx_ev.done & (!q.standby | wake);
  assign perr = q.par_en & ((q.nine_bit ? ^rx_ev.data : ^rx_ev.data[7:0]) != q.par_odd);
  assign stat = {q.tbe, q.tc, q.rbf, q.quiet, q.ovr, q.noise, q.fe, q.pe};

  always_comb begin
    logic [7:0] wd;
    logic [7:0] r;
    logic [10:0] frame;
    logic [3:0] blen;
    logic ld;
    wd = hwdata[7:0];
    r = 8'h00;
    frame = 11'h7ff;
    blen = len;
    ld = 1'b1;
    n = q;
    n.sync1 = serial_in;
    n.sync2 = q.sync1;
    n.a_valid = a_go & hwrite & (hsize == serial_ctrl_pkg::HSIZE_WORD);
    n.a_addr = haddr[7:0];
    // ----------------------------------------------------------------
    // register writes, data phase
    // ----------------------------------------------------------------
    if (wr_go) begin
      case (q.a_addr)
        serial_ctrl_pkg::OFS_CTRL: begin
          n.module_on = wd[serial_ctrl_pkg::CB_MODULE_ON];
          n.nine_bit = wd[serial_ctrl_pkg::CB_NINE];
          n.wake_sel = wd[serial_ctrl_pkg::CB_WAKE];
          n.par_en = wd[serial_ctrl_pkg::CB_PAR_EN];
          n.par_odd = wd[serial_ctrl_pkg::CB_PAR_ODD];
        end
        serial_ctrl_pkg::OFS_ENABLE: begin
          n.txempty_en = wd[serial_ctrl_pkg::EB_TXEMPTY_IE];
          n.txdone_en = wd[serial_ctrl_pkg::EB_TXDONE_IE];
          n.rxfull_en = wd[serial_ctrl_pkg::EB_RXFULL_IE];
          n.quiet_en = wd[serial_ctrl_pkg::EB_QUIET_IE];
          n.standby = wd[serial_ctrl_pkg::EB_STANDBY];
          n.break_send = wd[serial_ctrl_pkg::EB_BREAK];
          if (q.module_on) begin
            n.tx_on = wd[serial_ctrl_pkg::EB_TX_ON];
            n.rx_on = wd[serial_ctrl_pkg::EB_RX_ON];
            // a rising enable queues one character of ones
            if (wd[serial_ctrl_pkg::EB_TX_ON] & !q.tx_on) begin
              n.pre_pend = 1'b1;
            end
          end
        end
        serial_ctrl_pkg::OFS_NINTH: begin
          n.tx_ninth = wd[serial_ctrl_pkg::NB_TX_NINTH];
          n.or_en = wd[serial_ctrl_pkg::NB_OVR_IE];
          n.nf_en = wd[serial_ctrl_pkg::NB_NOISE_IE];
          n.fe_en = wd[serial_ctrl_pkg::NB_FRAME_IE];
          n.pe_en = wd[serial_ctrl_pkg::NB_PAR_IE];
        end
        serial_ctrl_pkg::OFS_DATA: begin
          n.tx_hold = wd;
          if (q.seen[serial_ctrl_pkg::SB_TBE]) begin
            n.tbe = 1'b0;
          end
          n.seen[serial_ctrl_pkg::SB_TBE] = 1'b0;
        end
        serial_ctrl_pkg::OFS_BAUD: n.baud = hwdata[15:0];
        default: ;
      endcase
    end
    // ----------------------------------------------------------------
    // two-step clearing: status read arms, data read clears
    // ----------------------------------------------------------------
    if (rd_data) begin
      n.rbf = q.rbf & !q.seen[serial_ctrl_pkg::SB_RBF];
      n.quiet = q.quiet & !q.seen[serial_ctrl_pkg::SB_QUIET];
      n.ovr = q.ovr & !q.seen[serial_ctrl_pkg::SB_OVR];
      n.noise = q.noise & !q.seen[serial_ctrl_pkg::SB_NOISE];
      n.fe = q.fe & !q.seen[serial_ctrl_pkg::SB_FRAME];
      n.pe = q.pe & !q.seen[serial_ctrl_pkg::SB_PAR];
      n.seen[5:0] = 6'h00;
    end
    if (rd_stat) begin
      n.seen = stat;
    end
    // ----------------------------------------------------------------
    // bit clock and transmitter
    // ----------------------------------------------------------------
    n.baud_cnt = (tick | !q.module_on) ? q.baud - 16'h0001 : q.baud_cnt - 16'h0001;
    if (!q.module_on) begin
      n.tx_bits = 4'h0;
      n.serial_out = 1'b1;
      n.pre_pend = 1'b0;
      n.brk_tail = 1'b0;
    end else if (tick) begin
      if (q.tx_bits > 4'h1) begin
        n.serial_out = q.tx_shift[0];
        n.tx_shift = {1'b1, q.tx_shift[10:1]};
        n.tx_bits = q.tx_bits - 4'h1;
      end else begin
        if (q.tx_on & q.break_send) begin
          // a pending preamble is replaced by the break
          frame = 11'h000;
          n.brk_tail = 1'b1;
          n.pre_pend = 1'b0;
        end else if (q.brk_tail) begin
          blen = 4'h1;
          n.brk_tail = 1'b0;
        end else if (q.tx_on & q.pre_pend) begin
          n.pre_pend = 1'b0;
        end else if (q.tx_on & !q.tbe) begin
          n.tbe = 1'b1;
          if (q.nine_bit) begin
            frame = {1'b1, q.par_en ? (^q.tx_hold ^ q.par_odd) : q.tx_ninth,
              q.tx_hold, 1'b0};
          end else begin
            frame = {2'b11, q.par_en ? (^q.tx_hold[6:0] ^ q.par_odd) : q.tx_hold[7],
              q.tx_hold[6:0], 1'b0};
          end
        end else begin
          ld = 1'b0;
        end
        n.serial_out = ld ? frame[0] : 1'b1;
        n.tx_shift = {1'b1, frame[10:1]};
        n.tx_bits = ld ? blen : 4'h0;
      end
    end
    // ----------------------------------------------------------------
    // receive flags: hardware sets are applied after the clears
    // ----------------------------------------------------------------
    if (!q.rx_on) begin
      n.quiet_armed = 1'b0;
    end
    if (accept) begin
      if (q.rbf) begin
        n.ovr = 1'b1;
      end else begin
        n.rbf = 1'b1;
        n.quiet_armed = 1'b1;
      end
      n.noise = n.noise | rx_ev.noise;
      n.fe = n.fe | rx_ev.framing;
      n.pe = n.pe | perr;
    end
    if (wake | (rx_ev.idle & q.standby & !q.wake_sel)) begin
      n.standby = 1'b0;
    end
    if (rx_ev.idle & q.quiet_armed) begin
      n.quiet = 1'b1;
      n.quiet_armed = 1'b0;
    end
    // ----------------------------------------------------------------
    // transmit completion and requests
    // ----------------------------------------------------------------
    n.tc = n.tbe & (n.tx_bits == 4'h0) & !n.brk_tail
      & !(n.tx_on & (n.pre_pend | n.break_send | !n.tbe));
    if (!n.module_on) begin
      n.tbe = 1'b1;
      n.tc = 1'b1;
    end
    n.irq_tx = n.module_on & (n.tbe & n.txempty_en | n.tc & n.txdone_en);
    n.irq_rx = !n.standby & (n.rbf & n.rxfull_en | n.quiet & n.quiet_en);
    n.irq_err = !n.standby & (n.ovr & n.or_en | n.noise & n.nf_en | n.fe & n.fe_en
      | n.pe & n.pe_en);
    // ----------------------------------------------------------------
    // read data, captured in the address phase
    // ----------------------------------------------------------------
    case (haddr[7:0])
      serial_ctrl_pkg::OFS_CTRL: begin
        r[serial_ctrl_pkg::CB_MODULE_ON] = n.module_on;
        r[serial_ctrl_pkg::CB_NINE] = n.nine_bit;
        r[serial_ctrl_pkg::CB_WAKE] = n.wake_sel;
        r[serial_ctrl_pkg::CB_PAR_EN] = n.par_en;
        r[serial_ctrl_pkg::CB_PAR_ODD] = n.par_odd;
      end
      serial_ctrl_pkg::OFS_ENABLE: begin
        r = {n.txempty_en, n.txdone_en, n.rxfull_en, n.quiet_en,
          n.tx_on, n.rx_on, n.standby, n.break_send};
      end
      serial_ctrl_pkg::OFS_NINTH: begin
        r = {rx_ninth, n.tx_ninth, 2'b00, n.or_en, n.nf_en, n.fe_en, n.pe_en};
      end
      serial_ctrl_pkg::OFS_STATUS: r = stat;
      serial_ctrl_pkg::OFS_DATA: r = data_buffer;
      default: r = 8'h00;
    endcase
    n.hrdata = {16'h0000, (haddr[7:0] == serial_ctrl_pkg::OFS_BAUD) ? n.baud : {8'h00, r}};
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.hreadyout <= 1'b1;
      q.baud <= serial_ctrl_pkg::BAUD_DIV_RESET;
      q.tbe <= 1'b1;
      q.tc <= 1'b1;
      q.serial_out <= 1'b1;
    end else if (ce) begin
      q <= n;
    end
  end

  // received data survives reset, so it sits outside the reset state
  always_ff @(posedge clock) begin
    if (ce & accept & !q.rbf) begin
      data_buffer <= rx_ev.data[7:0];
      rx_ninth <= q.nine_bit ? rx_ev.data[8] : rx_ev.data[7];
    end
  end

  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign hrdata = q.hrdata;
  assign serial_out = q.serial_out;
  assign irq_tx = q.irq_tx;
  assign irq_rx = q.irq_rx;
  assign irq_err = q.irq_err;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_enable_write_locked: assert property (
    (ce && wr_go && q.a_addr == serial_ctrl_pkg::OFS_ENABLE && !q.module_on)
    |=> (q.tx_on == $past(q.tx_on)) && (q.rx_on == $past(q.rx_on)))
    else $error("tx_on or rx_on changed while module off");
  a_line_high_off: assert property (
    (ce && tick && q.tx_bits <= 4'h1 && !q.tx_on && !q.brk_tail) |=> q.serial_out)
    else $error("line not idle high after transmitter off");
  a_break_low: assert property (
    (ce && tick && q.tx_bits <= 4'h1 && q.tx_on && q.break_send) |=> !q.serial_out
    ##0 q.tx_bits == len)
    else $error("break not started");
  a_standby_no_irq: assert property (
    q.standby |-> !q.irq_rx && !q.irq_err)
    else $error("receive request during standby");
  a_err_gated: assert property (
    (!q.or_en && !q.nf_en && !q.fe_en && !q.pe_en) |-> !q.irq_err)
    else $error("error request with all enables clear");
  a_tbe_clear_cause: assert property (
    $fell(q.tbe) |-> $past(wr_go && q.a_addr == serial_ctrl_pkg::OFS_DATA
    && q.seen[serial_ctrl_pkg::SB_TBE]))
    else $error("tx_buffer_empty cleared without sequence");
  a_tc_needs_tbe: assert property (
    q.tc |-> q.tbe && (q.tx_bits == 4'h0 || !q.module_on))
    else $error("tx_done_flag while busy");
  a_overrun_keeps: assert property (
    (ce && accept && q.rbf) |=> q.ovr && $stable(data_buffer))
    else $error("overrun lost buffered data");
  a_overrun_clear: assert property (
    $fell(q.ovr) |-> $past(rd_data && q.seen[serial_ctrl_pkg::SB_OVR]))
    else $error("overrun cleared without armed status read");
  a_quiet_armed: assert property (
    $rose(q.quiet) |-> $past(q.quiet_armed))
    else $error("line_quiet_flag without fresh character");
  a_module_off_tx: assert property (
    !q.module_on |-> q.tbe && q.tc && !q.irq_tx)
    else $error("transmit flags not forced with module off");

  c_preamble: cover property (ce && tick && q.tx_on && q.pre_pend && q.tx_bits <= 4'h1);
  c_overrun: cover property (ce && accept && q.rbf);
  c_break: cover property (q.brk_tail && !q.break_send);
  c_wake: cover property (ce && wake);
endmodule

// ===== serial_ctrl_pkg.sv
// shared offsets, field positions, reset values and types of the serial control block
package serial_ctrl_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_NINTH = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_BAUD = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CB_MODULE_ON = 6;
  localparam int CB_NINE = 4;
  localparam int CB_WAKE = 3;
  localparam int CB_PAR_EN = 1;
  localparam int CB_PAR_ODD = 0;
  localparam int EB_TXEMPTY_IE = 7;
  localparam int EB_TXDONE_IE = 6;
  localparam int EB_RXFULL_IE = 5;
  localparam int EB_QUIET_IE = 4;
  localparam int EB_TX_ON = 3;
  localparam int EB_RX_ON = 2;
  localparam int EB_STANDBY = 1;
  localparam int EB_BREAK = 0;
  localparam int NB_RX_NINTH = 7;
  localparam int NB_TX_NINTH = 6;
  localparam int NB_OVR_IE = 3;
  localparam int NB_NOISE_IE = 2;
  localparam int NB_FRAME_IE = 1;
  localparam int NB_PAR_IE = 0;
  localparam int SB_TBE = 7;
  localparam int SB_TC = 6;
  localparam int SB_RBF = 5;
  localparam int SB_QUIET = 4;
  localparam int SB_OVR = 3;
  localparam int SB_NOISE = 2;
  localparam int SB_FRAME = 1;
  localparam int SB_PAR = 0;
  // ----------------------------------------------------------------
  // timing and character format
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 100000000;
  localparam int BAUD_RATE = 115200;
  localparam logic [15:0] BAUD_DIV_RESET = 16'(CLOCK_HZ / BAUD_RATE);
  localparam logic [3:0] CHAR_LEN_8 = 4'ha;
  localparam logic [3:0] CHAR_LEN_9 = 4'hb;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} rx_state_t;
  typedef struct packed {
    logic done;
    logic idle;
    logic framing;
    logic noise;
    logic [8:0] data;
  } rx_event_t;
endpackage

// ===== serial_rx.sv
// receive shifter with noise, framing and idle-line detection
`timescale 1ns/1ns
module serial_rx (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic line,
  input wire logic nine_bit,
  input wire logic [15:0] bit_cycles,
  output serial_ctrl_pkg::rx_event_t rx_ev
);
  typedef struct packed {
    serial_ctrl_pkg::rx_state_t st;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [3:0] ones;
    logic [9:0] shift;
    logic early;
    logic noise;
    serial_ctrl_pkg::rx_event_t ev;
  } rx_st_t;
  rx_st_t q;
  rx_st_t n;
  logic [3:0] len;
  assign len = nine_bit ? serial_ctrl_pkg::CHAR_LEN_9 : serial_ctrl_pkg::CHAR_LEN_8;
  assign rx_ev = q.ev;

  always_comb begin
    logic [9:0] sh;
    sh = {line, q.shift[9:1]};
    n = q;
    n.ev.done = 1'b0;
    n.ev.idle = 1'b0;
    if (!enable) begin
      n.st = serial_ctrl_pkg::RX_HUNT;
      n.ones = 4'h0;
      n.cnt = bit_cycles - 16'h0001;
    end else begin
      case (q.st)
        serial_ctrl_pkg::RX_HUNT: begin
          if (!line) begin
            n.st = serial_ctrl_pkg::RX_START;
            n.cnt = {1'b0, bit_cycles[15:1]};
            n.ones = 4'h0;
          end else if (q.cnt == 16'h0000) begin
            n.cnt = bit_cycles - 16'h0001;
            // count ones up to one character length, then flag once
            if (q.ones != len) begin
              n.ones = q.ones + 4'h1;
              n.ev.idle = (q.ones + 4'h1) == len;
            end
          end else begin
            n.cnt = q.cnt - 16'h0001;
          end
        end
        serial_ctrl_pkg::RX_START: begin
          if (q.cnt == 16'h0000) begin
            // a high line at mid start bit is a false start
            n.st = line ? serial_ctrl_pkg::RX_HUNT : serial_ctrl_pkg::RX_BITS;
            n.cnt = bit_cycles - 16'h0001;
            n.bitn = 4'h0;
            n.noise = 1'b0;
          end else begin
            n.cnt = q.cnt - 16'h0001;
          end
        end
        serial_ctrl_pkg::RX_BITS: begin
          if (q.cnt == 16'h0001) begin
            n.early = line;
          end
          if (q.cnt == 16'h0000) begin
            n.shift = sh;
            n.noise = q.noise | (line != q.early);
            n.cnt = bit_cycles - 16'h0001;
            n.bitn = q.bitn + 4'h1;
            if (q.bitn == len - 4'h2) begin
              n.st = serial_ctrl_pkg::RX_HUNT;
              n.ev.done = 1'b1;
              n.ev.framing = !line;
              n.ev.noise = q.noise | (line != q.early);
              n.ev.data = nine_bit ? sh[8:0] : {1'b0, sh[8:1]};
            end
          end else begin
            n.cnt = q.cnt - 16'h0001;
          end
        end
        default: n.st = serial_ctrl_pkg::RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end
endmodule

// ===== serial_peer.sv
// remote serial peer: drives the receive line and decodes the transmit line
`timescale 1ns/1ns
module serial_peer #(
  parameter int BIT_CLKS = 8
) (
  input wire logic clock,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // frame of start, data lsb first, stop; a low stop level forces a framing fault
  task automatic send(input logic [8:0] d, input int nbits, input logic stop);
    rx_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      rx_line <= d[i];
      repeat (BIT_CLKS) @(posedge clock);
    end
    rx_line <= stop;
    repeat (BIT_CLKS) @(posedge clock);
    rx_line <= 1'b1;
  endtask
  // samples each bit in its middle, after the start bit is seen
  task automatic grab(output logic [7:0] d, output logic stop);
    wait (tx_line === 1'b0);
    repeat (BIT_CLKS / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clock);
      d[i] = tx_line;
    end
    repeat (BIT_CLKS) @(posedge clock);
    stop = tx_line;
  endtask
endmodule

// ===== testbench.sv
// self-checking bench for the serial control block and its remote peer
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] CT = serial_ctrl_pkg::OFS_CTRL;
  localparam logic [7:0] EN = serial_ctrl_pkg::OFS_ENABLE;
  localparam logic [7:0] NI = serial_ctrl_pkg::OFS_NINTH;
  localparam logic [7:0] ST = serial_ctrl_pkg::OFS_STATUS;
  localparam logic [7:0] DT = serial_ctrl_pkg::OFS_DATA;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, serial_in, serial_out, irq_tx, irq_rx, irq_err, s;
  logic [31:0] hrdata, v;
  logic [7:0] b;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] wd;
    logic [7:0] m;
    logic [7:0] e;
  } row_t;
  row_t rows [7] = '{
    '{EN, 8'h0c, 8'hff, 8'h00},
    // bit period set while the module is off, so the bit clock starts in step
    '{serial_ctrl_pkg::OFS_BAUD, 8'h08, 8'hff, 8'h08},
    '{CT, 8'h40, 8'hff, 8'h40},
    '{NI, 8'h4f, 8'h7f, 8'h4f},
    '{NI, 8'h00, 8'h7f, 8'h00},
    '{8'h20, 8'hff, 8'hff, 8'h00},
    '{ST, 8'h00, 8'hff, 8'hc0}
  };
  always #5 clock = ~clock;
  serial_ctrl dut (.clock(clock), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(serial_ctrl_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .serial_in(serial_in), .serial_out(serial_out), .irq_tx(irq_tx),
    .irq_rx(irq_rx), .irq_err(irq_err));
  serial_peer #(.BIT_CLKS(8)) peer (.clock(clock), .tx_line(serial_out), .rx_line(serial_in));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // the whole run needs about 1500 cycles; this ceiling only cuts a hang
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    v = hrdata;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    bus(a, 1'b0, 32'h0);
    check(n, v & {24'h0, m}, {24'h0, e});
  endtask
  task automatic wait_char(input logic [7:0] d, input logic stop);
    peer.send({1'b0, d}, 8, stop);
    repeat (8) @(posedge clock);
  endtask
  task automatic wait_nine(input logic [8:0] d);
    peer.send(d, 9, 1'b1);
    repeat (8) @(posedge clock);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rchk("status", ST, 8'hff, 8'hc0);
    rchk("ninth", NI, 8'h7f, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      bus(rows[i].a, 1'b1, {24'h0, rows[i].wd});
      rchk("row", rows[i].a, rows[i].m, rows[i].e);
    end
    $display("test table done");
    bus(EN, 1'b1, 32'h48);
    t0 = cyc;
    rchk("tbe", ST, 8'h80, 8'h80);
    bus(DT, 1'b1, 32'ha5);
    rchk("queued", ST, 8'hc0, 8'h00);
    peer.grab(b, s);
    // ten ones of preamble, then start and eight data bits, place the stop sample late
    check("preamble", {31'h0, (cyc - t0) >= 150}, 32'h1);
    check("txdata", {24'h0, b}, 32'ha5);
    check("txstop", {31'h0, s}, 32'h1);
    repeat (16) @(posedge clock);
    rchk("txidle", ST, 8'hc0, 8'hc0);
    check("irqtx", {31'h0, irq_tx}, 32'h1);
    $display("test transmit done");
    bus(EN, 1'b1, 32'h2c);
    wait_char(8'hc3, 1'b1);
    check("irqrx", {31'h0, irq_rx}, 32'h1);
    rchk("rbf", ST, 8'h20, 8'h20);
    rchk("rxdata", DT, 8'hff, 8'hc3);
    rchk("r8", NI, 8'h80, 8'h80);
    rchk("rbfclr", ST, 8'h20, 8'h00);
    repeat (100) @(posedge clock);
    rchk("quiet", ST, 8'h10, 8'h10);
    bus(DT, 1'b0, 32'h0);
    repeat (100) @(posedge clock);
    rchk("quietagain", ST, 8'h10, 8'h00);
    $display("test receive done");
    bus(NI, 1'b1, 32'h08);
    wait_char(8'h11, 1'b1);
    wait_char(8'h22, 1'b1);
    rchk("ovr", ST, 8'h28, 8'h28);
    check("irqerr", {31'h0, irq_err}, 32'h1);
    rchk("kept", DT, 8'hff, 8'h11);
    rchk("ovrclr", ST, 8'h28, 8'h00);
    wait_char(8'h33, 1'b1);
    bus(ST, 1'b0, 32'h0);
    wait_char(8'h44, 1'b1);
    bus(DT, 1'b0, 32'h0);
    rchk("ovrlate", ST, 8'h08, 8'h08);
    bus(DT, 1'b0, 32'h0);
    $display("test overrun done");
    bus(NI, 1'b1, 32'h02);
    wait_char(8'h55, 1'b0);
    rchk("fe", ST, 8'h02, 8'h02);
    check("irqfe", {31'h0, irq_err}, 32'h1);
    bus(CT, 1'b1, 32'h0);
    rchk("off", ST, 8'hc0, 8'hc0);
    bus(DT, 1'b0, 32'h0);
    $display("test framing and disable done");
    // 9-bit characters, standby left only on an address mark
    bus(CT, 1'b1, 32'h58);
    bus(EN, 1'b1, 32'h26);
    wait_nine({1'b0, 8'h5a});
    check("irqsb", {31'h0, irq_rx}, 32'h0);
    rchk("sbdrop", ST, 8'h20, 8'h00);
    rchk("sbhold", EN, 8'h02, 8'h02);
    wait_nine({1'b1, 8'h3c});
    rchk("sbwake", EN, 8'h02, 8'h00);
    bus(EN, 1'b1, 32'h20);
    rchk("rxoffkeep", ST, 8'h20, 8'h20);
    rchk("rx9data", DT, 8'hff, 8'h3c);
    rchk("rx9bit", NI, 8'h80, 8'h80);
    $display("test standby and ninth bit done");
    // break_send is set only after the preamble of the fresh tx_on has gone out, since a break replaces a pending preamble
    bus(EN, 1'b1, 32'h08);
    repeat (100) @(posedge clock);
    bus(EN, 1'b1, 32'h09);
    wait (serial_out === 1'b0);
    t0 = cyc;
    repeat (100) @(posedge clock);
    check("brkheld", {31'h0, serial_out}, 32'h0);
    rchk("brkbusy", ST, 8'h40, 8'h00);
    bus(EN, 1'b1, 32'h08);
    wait (serial_out === 1'b1);
    // two breaks of eleven bit periods of eight clocks, nothing between them
    check("brklen", cyc - t0, 32'h000000b0);
    repeat (20) @(posedge clock);
    check("brktail", {31'h0, serial_out}, 32'h1);
    rchk("brkdone", ST, 8'h40, 8'h40);
    $display("test break done");
    // second reset: received ninth bit survives, transmitted one clears
    bus(NI, 1'b1, 32'h40);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rchk("rstninth", NI, 8'hc0, 8'h80);
    rchk("rstst", ST, 8'hff, 8'hc0);
    $display("test second reset done");
    wrap_up();
  end
endmodule
